// File: hw/pws_pkg.sv
// Purpose: constants and types for the pulsed waveform sequencer
// Assumes: 50 MHz system clock, registers on a plain strobe port
// Notes: hold times count in 4 us ticks from a divider
// Operation
// - Six signed point values, indexed 0 to 5, are stored and read back.
// - Point values are limited to +-15000 mV in potential mode, +-2000 (or +-1000 on the 1 A range) in current mode.
// - Each point holds its output for a 24-bit count of 4 us ticks, at least 1.
// - With the add flag set the output is value plus baseline, otherwise value plus zero.
// - When a hold expires the baseline steps if the increment flag is 0 and stays if it is 1.
// - The initial hold point is played once, its flags are ignored and read back as zero.
// - A 20-bit baseline step limit from 1 to 1048575 is held.
// - End mode 0 reverses the step direction at each limit, mode 1 stops at the limit.
// - The verify code is zero when complete, bit 0 set when a used point lacks data.
// - Start mode 0 runs at once, mode 1 arms and waits for the scan trigger.
// - Stop halts sequencing while the control loop stays closed.
// - Active points are the point count plus one, and the sequence loops back to point 1.
// - Each baseline step adds, or after a reversal subtracts, a signed step size within +-15000.
`default_nettype none
package pws_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned TICK_NS = 4000;
    localparam int unsigned TICK_CYC = (TICK_NS * (CLK_HZ / 1000000)) / 1000;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0c;
    localparam logic [7:0] ADDR_VERIFY = 8'h10;
    localparam logic [7:0] ADDR_NPTS = 8'h14;
    localparam logic [7:0] ADDR_STEP = 8'h18;
    localparam logic [7:0] ADDR_LIMIT = 8'h1c;
    localparam logic [7:0] ADDR_OUT = 8'h20;
    localparam logic [7:0] ADDR_VAL0 = 8'h40;
    localparam logic [7:0] ADDR_HOLD0 = 8'h60;
    localparam logic [7:0] ADDR_FLAG0 = 8'h80;
    localparam int CTRL_CURRENT = 0;
    localparam int CTRL_RANGE1A = 1;
    localparam int CTRL_ENDMODE = 2;
    localparam int CMD_INIT = 0;
    localparam int CMD_START = 1;
    localparam int CMD_ARM = 2;
    localparam int CMD_STOP = 3;
    localparam int FLAG_ADD = 0;
    localparam int FLAG_KEEP = 1;
    localparam int ST_DONE = 0;
    localparam int ST_REVERSE = 1;
    localparam int ST_STARTED = 2;
    localparam logic signed [15:0] LIM_MV = 16'sd15000;
    localparam logic signed [15:0] LIM_CUR = 16'sd2000;
    localparam logic signed [15:0] LIM_CUR1A = 16'sd1000;
    localparam logic [23:0] HOLD_MAX = 24'hffffff;
    localparam logic [19:0] LIMIT_MAX = 20'hfffff;
    localparam logic [2:0] NPTS_MAX = 3'h5;
    localparam logic [2:0] NPTS_RST = 3'h1;
    localparam logic [19:0] LIMIT_RST = 20'h00001;
    localparam logic [7:0] VERIFY_MISSING = 8'h01;
    typedef enum logic [1:0] {
        PWS_IDLE = 2'b00,
        PWS_ARMED = 2'b01,
        PWS_RUN = 2'b10
    } pws_state_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pws_bus_t;
endpackage : pws_pkg
`default_nettype wire

// File: hw/pws_sequencer.sv
// Purpose: pulsed waveform sequencer with point table, baseline stepping and end modes
// Assumes: single clock, inputs synchronous, host checks verify code before start
// Notes: drive output is a signed 17-bit code in mV or thousandths of range
`timescale 1ns/1ps
`default_nettype none
module pws_sequencer
    import pws_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic scan_trigger_in,
    output logic [31:0] rdata_out,
    output logic signed [16:0] drive_out,
    output logic loop_closed_out,
    output logic running_out,
    output logic irq_out
);
    pws_bus_t bus;
    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    logic signed [15:0] point_val [0:5];
    logic [23:0] point_hold [0:5];
    logic [1:0] point_flag [0:5];
    logic [5:0] val_set;
    logic [5:0] hold_set;
    logic [2:0] ctrl;
    logic [2:0] npts;
    logic signed [15:0] step;
    logic [19:0] limit;
    logic [2:0] status;
    logic [2:0] mask;
    logic inited;
    pws_state_t state;
    logic [2:0] idx;
    logic [23:0] hold_cnt;
    logic [19:0] step_cnt;
    logic dir_down;
    logic signed [16:0] baseline;
    logic [7:0] tick_div;
    logic tick;
    logic [2:0] ev;

    function automatic logic in_range(input logic signed [31:0] v, input logic [2:0] c);
        logic signed [31:0] lim;
        lim = 32'(c[CTRL_CURRENT] ? (c[CTRL_RANGE1A] ? LIM_CUR1A : LIM_CUR) : LIM_MV);
        return (v <= lim) && (v >= -lim);
    endfunction : in_range

    function automatic logic [2:0] slot(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        return (a >= base && d[7:2] < 6'h06 && d[1:0] == 2'b00) ? d[4:2] : 3'h7;
    endfunction : slot

    wire logic cmd_wr = bus.wr && bus.addr == ADDR_CMD;
    wire logic do_init = cmd_wr && bus.wdata[CMD_INIT];
    wire logic do_stop = cmd_wr && bus.wdata[CMD_STOP];
    wire logic do_start = cmd_wr && (bus.wdata[CMD_START] || bus.wdata[CMD_ARM]) && inited;
    wire logic do_arm = do_start && bus.wdata[CMD_ARM];
    wire logic [5:0] used = 6'((7'h02 << npts) - 7'h01);
    wire logic [7:0] verify = ((used & ~(val_set & hold_set)) != 6'h00) ? VERIFY_MISSING : 8'h00;
    wire logic hold_end = state == PWS_RUN && tick && hold_cnt <= 24'h000001;
    wire logic step_now = hold_end && idx != 3'h0 && !point_flag[idx][FLAG_KEEP];
    wire logic at_limit = step_now && step_cnt + 20'h00001 >= limit;
    wire logic stop_now = at_limit && ctrl[CTRL_ENDMODE];
    wire logic [2:0] next_idx = (idx >= npts) ? 3'h1 : idx + 3'h1;

    // Point table writes; bad index or value leaves the old entry alone
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 6; i++) begin
                point_val[i] <= 16'sh0000;
                point_hold[i] <= 24'h000001;
                point_flag[i] <= 2'b00;
            end
            val_set <= 6'h00;
            hold_set <= 6'h00;
        end else if (bus.wr) begin
            if (slot(bus.addr, ADDR_VAL0) != 3'h7 && in_range(bus.wdata, ctrl)) begin
                point_val[slot(bus.addr, ADDR_VAL0)] <= bus.wdata[15:0];
                val_set[slot(bus.addr, ADDR_VAL0)] <= 1'b1;
            end
            if (slot(bus.addr, ADDR_HOLD0) != 3'h7 && bus.wdata[31:24] == 8'h00
                && bus.wdata[23:0] != 24'h000000) begin
                point_hold[slot(bus.addr, ADDR_HOLD0)] <= bus.wdata[23:0];
                hold_set[slot(bus.addr, ADDR_HOLD0)] <= 1'b1;
            end
            if (slot(bus.addr, ADDR_FLAG0) != 3'h7 && slot(bus.addr, ADDR_FLAG0) != 3'h0) begin
                point_flag[slot(bus.addr, ADDR_FLAG0)] <= bus.wdata[1:0];
            end
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl <= 3'h0;
            npts <= NPTS_RST;
            step <= 16'sh0000;
            limit <= LIMIT_RST;
            mask <= 3'h0;
        end else if (bus.wr) begin
            case (bus.addr)
                ADDR_CTRL: ctrl <= bus.wdata[2:0];
                ADDR_MASK: mask <= bus.wdata[2:0];
                ADDR_NPTS: begin
                    if (bus.wdata >= 32'h1 && bus.wdata <= 32'(NPTS_MAX)) begin
                        npts <= bus.wdata[2:0];
                    end
                end
                ADDR_STEP: begin
                    if ($signed(bus.wdata) <= 32'(LIM_MV) && $signed(bus.wdata) >= -32'(LIM_MV)) begin
                        step <= bus.wdata[15:0];
                    end
                end
                ADDR_LIMIT: begin
                    if (bus.wdata >= 32'h1 && bus.wdata <= 32'(LIMIT_MAX)) begin
                        limit <= bus.wdata[19:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // 4 us tick
    // A restart mid-count must not shorten the first hold
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tick_div <= 8'h00;
        end else if (state != PWS_RUN || tick || do_start) begin
            tick_div <= 8'h00;
        end else begin
            tick_div <= tick_div + 8'h01;
        end
    end
    assign tick = state == PWS_RUN && tick_div == 8'(TICK_CYC - 1);

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            inited <= 1'b0;
            loop_closed_out <= 1'b0;
        end else begin
            if (do_init) begin
                inited <= 1'b1;
            end
            if (do_start) begin
                loop_closed_out <= 1'b1;
            end
        end
    end

    // Sequencer
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= PWS_IDLE;
            idx <= 3'h0;
            hold_cnt <= 24'h000001;
            step_cnt <= 20'h00000;
            dir_down <= 1'b0;
            baseline <= 17'sh00000;
        end else if (do_stop) begin
            state <= PWS_IDLE;
        end else if (do_start) begin
            state <= do_arm ? PWS_ARMED : PWS_RUN;
            idx <= 3'h0;
            hold_cnt <= point_hold[0];
            step_cnt <= 20'h00000;
            dir_down <= 1'b0;
            baseline <= 17'sh00000;
        end else begin
            case (state)
                PWS_ARMED: begin
                    if (scan_trigger_in) begin
                        state <= PWS_RUN;
                    end
                end
                PWS_RUN: begin
                    if (hold_end) begin
                        idx <= next_idx;
                        hold_cnt <= point_hold[next_idx];
                    end else if (tick) begin
                        hold_cnt <= hold_cnt - 24'h000001;
                    end
                    if (step_now) begin
                        baseline <= dir_down ? baseline - 17'(step) : baseline + 17'(step);
                        step_cnt <= at_limit ? 20'h00000 : step_cnt + 20'h00001;
                        if (at_limit) begin
                            dir_down <= ~dir_down;
                        end
                    end
                    if (stop_now) begin
                        state <= PWS_IDLE;
                    end
                end
                default: state <= PWS_IDLE;
            endcase
        end
    end

    // Drive output register
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            drive_out <= 17'sh00000;
        end else if (state == PWS_RUN) begin
            if (idx != 3'h0 && point_flag[idx][FLAG_ADD]) begin
                drive_out <= 17'(point_val[idx]) + baseline;
            end else begin
                drive_out <= 17'(point_val[idx]);
            end
        end
    end
    assign running_out = state == PWS_RUN;

    // Sticky events, set beats a write-one clear
    assign ev = {do_start, at_limit && !ctrl[CTRL_ENDMODE], stop_now};
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            status <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (ev[i]) begin
                    status[i] <= 1'b1;
                end else if (bus.wr && bus.addr == ADDR_STATUS && bus.wdata[i]) begin
                    status[i] <= 1'b0;
                end
            end
        end
    end
    assign irq_out = (status & mask) != 3'h0;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_out <= 32'h00000000;
        end else if (bus.rd) begin
            rdata_out <= 32'h00000000;
            if (slot(bus.addr, ADDR_VAL0) != 3'h7) begin
                rdata_out <= 32'($signed(point_val[slot(bus.addr, ADDR_VAL0)]));
            end else if (slot(bus.addr, ADDR_HOLD0) != 3'h7) begin
                rdata_out <= {8'h00, point_hold[slot(bus.addr, ADDR_HOLD0)]};
            end else if (slot(bus.addr, ADDR_FLAG0) != 3'h7) begin
                rdata_out <= {30'h0, point_flag[slot(bus.addr, ADDR_FLAG0)]};
            end else begin
                case (bus.addr)
                    ADDR_CTRL: rdata_out <= {29'h0, ctrl};
                    ADDR_CMD: rdata_out <= {29'h0, loop_closed_out, state};
                    ADDR_STATUS: rdata_out <= {29'h0, status};
                    ADDR_MASK: rdata_out <= {29'h0, mask};
                    ADDR_VERIFY: rdata_out <= {24'h0, verify};
                    ADDR_NPTS: rdata_out <= {29'h0, npts};
                    ADDR_STEP: rdata_out <= 32'($signed(step));
                    ADDR_LIMIT: rdata_out <= {12'h0, limit};
                    ADDR_OUT: rdata_out <= 32'($signed(drive_out));
                    default: rdata_out <= 32'h00000000;
                endcase
            end
        end
    end

    property p_init_gate;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        !inited |=> state == PWS_IDLE || inited;
    endproperty
    a_init_gate: assert property (p_init_gate) else $error("ran without init");

    sequence s_arm;
        do_arm ##1 (state == PWS_ARMED && !scan_trigger_in && !cmd_wr);
    endsequence
    property p_arm_wait;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        s_arm |=> state == PWS_ARMED;
    endproperty
    a_arm_wait: assert property (p_arm_wait) else $error("armed state left without trigger");

    property p_stop;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        do_stop |=> state == PWS_IDLE && $stable(loop_closed_out);
    endproperty
    a_stop: assert property (p_stop) else $error("stop failed");

    property p_loop;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        hold_end && idx == npts && !do_stop && !do_start |=> idx == 3'h1;
    endproperty
    a_loop: assert property (p_loop) else $error("did not loop to point 1");

    property p_keep;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        hold_end && point_flag[idx][FLAG_KEEP] && !cmd_wr |=> $stable(baseline);
    endproperty
    a_keep: assert property (p_keep) else $error("baseline moved");

    property p_end_stop;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        stop_now && !cmd_wr |=> state == PWS_IDLE;
    endproperty
    a_end_stop: assert property (p_end_stop) else $error("no stop at limit");

    property p_flag0;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        point_flag[0] == 2'b00;
    endproperty
    a_flag0: assert property (p_flag0) else $error("point 0 flags set");

    property p_verify;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        bus.rd && bus.addr == ADDR_VERIFY |=> rdata_out[31:1] == 31'h0;
    endproperty
    a_verify: assert property (p_verify) else $error("verify reserved bits");

    property p_hold_range;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        bus.wr && slot(bus.addr, ADDR_HOLD0) == 3'h0 && bus.wdata == 32'h0 |=> $stable(point_hold[0]);
    endproperty
    a_hold_range: assert property (p_hold_range) else $error("zero hold taken");

    property p_reload;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        hold_end && !bus.wr |=> hold_cnt == point_hold[idx];
    endproperty
    a_reload: assert property (p_reload) else $error("hold count not reloaded");

    property p_reverse;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        at_limit && !ctrl[CTRL_ENDMODE] && !bus.wr |=> dir_down != $past(dir_down);
    endproperty
    a_reverse: assert property (p_reverse) else $error("direction not reversed at limit");

    property p_hold_drive;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        state != PWS_RUN |=> $stable(drive_out);
    endproperty
    a_hold_drive: assert property (p_hold_drive) else $error("drive moved while halted");

    // Every start without a stop in the same command replays the initial hold point from a fresh tick
    sequence s_restart;
        do_start && !do_stop;
    endsequence
    property p_restart;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        s_restart |=> idx == 3'h0 && baseline == 17'sh00000 && tick_div == 8'h00;
    endproperty
    a_restart: assert property (p_restart) else $error("start did not begin at point 0");
endmodule : pws_sequencer
`default_nettype wire

// File: verif/pws_host.sv
// Purpose: host model that programs the sequencer over the strobe port
// Assumes: one clock, read data stand in the cycle after the read strobe
// Notes: every signal changes right after a rising edge; strobes last one cycle
`timescale 1ns/1ps
`default_nettype none
module pws_host
    import pws_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic [31:0] rdata_in,
    output logic [7:0] addr_out,
    output logic [31:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 32'h0;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge sys_clk_in);
        wr_out <= 1'b0;
        // Stale data would hide a missing strobe qualifier
        wdata_out <= ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge sys_clk_in);
        rd_out <= 1'b0;
        #1 d = rdata_in;
    endtask : rd_reg

    // Verify code is always fetched before a start or arm
    task automatic launch(input logic [31:0] cmd, output logic [31:0] code);
        rd_reg(ADDR_VERIFY, code);
        wr_reg(ADDR_CMD, cmd);
    endtask : launch
endmodule : pws_host
`default_nettype wire

// File: verif/pws_sequencer_tb.sv
// Purpose: self-checking bench for the pulsed waveform sequencer
// Assumes: 50 MHz clock, hold of one tick lasts 200 cycles
// Notes: drive is sampled mid-hold so tick alignment slop cannot matter
`timescale 1ns/1ps
`default_nettype none
module pws_sequencer_tb;
    import pws_pkg::*;
    logic sys_clk_in, sys_rst_in, scan_trigger_in, wr, rd, loop_closed, running, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rv, code;
    logic signed [16:0] drive;
    int num_errors = 0;
    int check_count = 0;
    int val[6], flg[6], exq[$];
    int stp, lim, endm;

    pws_host HOST (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd));
    pws_sequencer DUT (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .scan_trigger_in(scan_trigger_in), .rdata_out(rdata), .drive_out(drive),
        .loop_closed_out(loop_closed), .running_out(running), .irq_out(irq));

    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        HOST.rd_reg(a, rv);
        chk($sformatf("reg %h", a), e & m, rv & m);
    endtask : chk_rd

    task automatic chk_drv(input int e);
        #1 chk("drive", 32'(e) & 32'h1ffff, {15'h0, drive});
    endtask : chk_drv

    // Reference sequence: point 0 once, then 1..npts looping, baseline per flags
    function automatic void build(input int npts, input int nseg);
        int base = 0;
        int dir = 1;
        int cnt = 0;
        int p = 0;
        int o = 0;
        bit done = 0;
        exq.delete();
        for (int s = 0; s < nseg; s++) begin
            if (!done) begin
                o = (p > 0 && flg[p][0]) ? val[p] + base : val[p];
                if (p > 0 && !flg[p][1]) begin
                    base += dir * stp;
                    cnt++;
                    if (cnt == lim) begin
                        if (endm != 0) done = 1;
                        else begin
                            dir = -dir;
                            cnt = 0;
                        end
                    end
                end
                p = (p == npts) ? 1 : p + 1;
            end
            exq.push_back(o);
        end
    endfunction : build

    task automatic run_chk(input int npts, input int nseg);
        build(npts, nseg);
        repeat (100) @(posedge sys_clk_in);
        foreach (exq[k]) begin
            chk_drv(exq[k]);
            repeat (200) @(posedge sys_clk_in);
        end
    endtask : run_chk

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize

    initial begin
        repeat (30000) @(posedge sys_clk_in);
        num_errors++;
        summarize();
    end

    initial begin
        sys_rst_in = 1'b1;
        scan_trigger_in = 1'b0;
        rv = $urandom(32'hac05);
        repeat (20) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        chk_rd(ADDR_NPTS, 32'h1, 32'h7);
        chk_rd(ADDR_LIMIT, 32'h1, 32'hfffff);
        chk_rd(ADDR_VERIFY, 32'(VERIFY_MISSING), 32'hff);
        chk_rd(8'h3c, 32'h0, 32'hffffffff);
        for (int i = 0; i < 6; i++) begin
            val[i] = int'($urandom_range(2000)) - 1000;
            HOST.wr_reg(ADDR_VAL0 + 8'(4 * i), 32'(val[i]));
            HOST.wr_reg(ADDR_VAL0 + 8'(4 * i), 32'd15001);
            chk_rd(ADDR_VAL0 + 8'(4 * i), 32'(val[i]), 32'hffff);
        end
        HOST.wr_reg(ADDR_CTRL, 32'h1);
        HOST.wr_reg(ADDR_VAL0 + 8'h14, 32'd1500);
        HOST.wr_reg(ADDR_VAL0 + 8'h14, 32'd2001);
        chk_rd(ADDR_VAL0 + 8'h14, 32'd1500, 32'hffff);
        HOST.wr_reg(ADDR_CTRL, 32'h3);
        HOST.wr_reg(ADDR_VAL0 + 8'h14, 32'd1001);
        chk_rd(ADDR_VAL0 + 8'h14, 32'd1500, 32'hffff);
        HOST.wr_reg(ADDR_HOLD0 + 8'h14, 32'hffffff);
        HOST.wr_reg(ADDR_HOLD0 + 8'h14, 32'h0);
        HOST.wr_reg(ADDR_HOLD0 + 8'h14, 32'h1000000);
        chk_rd(ADDR_HOLD0 + 8'h14, 32'hffffff, 32'hffffffff);
        HOST.wr_reg(ADDR_HOLD0, 32'h0);
        chk_rd(ADDR_HOLD0, 32'h1, 32'hffffffff);
        HOST.wr_reg(ADDR_LIMIT, 32'hfffff);
        HOST.wr_reg(ADDR_LIMIT, 32'h0);
        chk_rd(ADDR_LIMIT, 32'hfffff, 32'hffffffff);
        HOST.wr_reg(ADDR_NPTS, 32'h6);
        chk_rd(ADDR_NPTS, 32'h1, 32'h7);
        HOST.wr_reg(ADDR_FLAG0, 32'h3);
        chk_rd(ADDR_FLAG0, 32'h0, 32'hffffffff);
        stp = int'($urandom_range(500, 1));
        HOST.wr_reg(ADDR_STEP, 32'(stp));
        HOST.wr_reg(ADDR_STEP, 32'd15001);
        chk_rd(ADDR_STEP, 32'(stp), 32'hffff);
        // Run with stop at the limit: point 1 adds and steps, point 2 neither
        endm = 1;
        lim = 2;
        flg[1] = 1;
        flg[2] = 2;
        HOST.wr_reg(ADDR_CTRL, 32'h4);
        HOST.wr_reg(ADDR_NPTS, 32'h2);
        HOST.wr_reg(ADDR_LIMIT, 32'h2);
        HOST.wr_reg(ADDR_MASK, 32'h1);
        chk_rd(ADDR_CTRL, 32'h4, 32'h7);
        chk_rd(ADDR_MASK, 32'h1, 32'h7);
        for (int i = 0; i < 3; i++) begin
            HOST.wr_reg(ADDR_VAL0 + 8'(4 * i), 32'(val[i]));
            HOST.wr_reg(ADDR_HOLD0 + 8'(4 * i), 32'h1);
            HOST.wr_reg(ADDR_FLAG0 + 8'(4 * i), 32'(flg[i]));
        end
        HOST.launch(32'h1 << CMD_START, code);
        chk("verify", 32'h0, code);
        repeat (3) @(posedge sys_clk_in);
        chk("run before init", 32'h0, {31'h0, running});
        HOST.wr_reg(ADDR_CMD, 32'h1 << CMD_INIT);
        HOST.launch(32'h1 << CMD_START, code);
        #1 chk("started", 32'h3, {30'h0, loop_closed, running});
        chk("irq masked", 32'h0, {31'h0, irq});
        run_chk(2, 5);
        chk("stopped at limit", 32'h0, {31'h0, running});
        chk("irq", 32'h1, {31'h0, irq});
        chk_rd(ADDR_STATUS, 32'h5, 32'h7);
        HOST.wr_reg(ADDR_STATUS, 32'h7);
        #1 chk("irq cleared", 32'h0, {31'h0, irq});
        // Reversing run
        endm = 0;
        lim = 1;
        HOST.wr_reg(ADDR_CTRL, 32'h0);
        HOST.wr_reg(ADDR_NPTS, 32'h1);
        HOST.wr_reg(ADDR_LIMIT, 32'h1);
        HOST.launch(32'h1 << CMD_START, code);
        run_chk(1, 4);
        chk_rd(ADDR_STATUS, 32'h2, 32'h2);
        // Armed start waits for the scan trigger
        HOST.launch(32'h1 << CMD_ARM, code);
        repeat (5) @(posedge sys_clk_in);
        chk_rd(ADDR_CMD, 32'h5, 32'h7);
        @(posedge sys_clk_in);
        scan_trigger_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        scan_trigger_in <= 1'b0;
        #1 chk("triggered", 32'h1, {31'h0, running});
        repeat (300) @(posedge sys_clk_in);
        // Restart lands mid-tick, so a stale divider would cut the first hold short
        HOST.launch(32'h1 << CMD_START, code);
        run_chk(1, 4);
        HOST.wr_reg(ADDR_CMD, 32'h1 << CMD_STOP);
        #1 chk("stop", 32'h2, {30'h0, loop_closed, running});
        rv = {15'h0, drive};
        repeat (400) @(posedge sys_clk_in);
        chk("held drive", rv, {15'h0, drive});
        chk_rd(ADDR_OUT, rv, 32'h1ffff);
        summarize();
    end
endmodule : pws_sequencer_tb
`default_nettype wire
